// ===== hdl/mts_pkg.sv
// Package for the measurement trigger sequencer: register map, event codes, fields.
// Assumes a single 100 MHz clock domain and a plain strobe register port.
package mts_pkg;

	// ----------------------------------------
	// Register map (byte offsets)
	// ----------------------------------------
	localparam logic [7:0] MTS_REG_CTRL   = 8'h00;
	localparam logic [7:0] MTS_REG_COUNT  = 8'h04;
	localparam logic [7:0] MTS_REG_CMD    = 8'h08;
	localparam logic [7:0] MTS_REG_STATUS = 8'h0c;
	localparam logic [7:0] MTS_REG_IRQ    = 8'h10;
	localparam logic [7:0] MTS_REG_MASK   = 8'h14;
	localparam logic [7:0] MTS_REG_LEFT   = 8'h18;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int MTS_ARM_LSB   = 0;
	localparam int MTS_TRIG_LSB  = 4;
	localparam int MTS_SAMP_LSB  = 8;
	localparam int MTS_SEL_W     = 3;
	localparam int MTS_STORE_BIT = 12;
	localparam int MTS_CMD_SGL   = 0;
	localparam int MTS_CMD_ARM   = 1;
	localparam int MTS_CMD_PRE   = 2;
	localparam int MTS_CMD_SON   = 3;
	localparam int MTS_CMD_SOFF  = 4;
	localparam int MTS_IRQ_W     = 4;
	localparam int MTS_IRQ_OVL   = 0;
	localparam int MTS_IRQ_ILL   = 1;
	localparam int MTS_IRQ_DONE  = 2;
	localparam int MTS_IRQ_RDG   = 3;

	// ----------------------------------------
	// Event sources for each stage
	// ----------------------------------------
	typedef enum logic [2:0] {
		MTS_EV_AUTO  = 3'b000,
		MTS_EV_EXT   = 3'b001,
		MTS_EV_SYN   = 3'b010,
		MTS_EV_SGL   = 3'b011,
		MTS_EV_LINE  = 3'b100,
		MTS_EV_LEVEL = 3'b101,
		MTS_EV_TIMER = 3'b110,
		MTS_EV_HOLD  = 3'b111
	} mts_event_e;

	// Default setup: arm free-running, trigger on host request, sample free-running
	localparam mts_event_e MTS_RST_ARM  = MTS_EV_AUTO;
	localparam mts_event_e MTS_RST_TRIG = MTS_EV_SYN;
	localparam mts_event_e MTS_RST_SAMP = MTS_EV_AUTO;
	localparam logic [15:0] MTS_RST_COUNT = 16'h0001;

	typedef enum logic [1:0] {
		MTS_ST_ARM  = 2'b00,
		MTS_ST_TRIG = 2'b01,
		MTS_ST_SAMP = 2'b10,
		MTS_ST_MEAS = 2'b11
	} mts_state_e;

	// Event inputs: pin edges after synchronisation, host request gated but not synchronised
	typedef struct packed {
		logic ext_fall;
		logic host_req;
		logic line_cross;
		logic level_hit;
		logic timer_tick;
	} mts_events_s;

	typedef struct packed {
		mts_event_e arm_sel;
		mts_event_e trig_sel;
		mts_event_e samp_sel;
	} mts_setup_s;

endpackage : mts_pkg

// ===== hdl/mts_edge_sync.sv
// Two-flop synchroniser with falling- and rising-edge detect for pin inputs.
// Assumes asynchronous pins; edge logic reads only the second flop onward.
`timescale 1ns/100ps
module mts_edge_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_in,
	input  wire logic             rst_b_in,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out,
	output logic      [WIDTH-1:0] fall_out,
	output logic      [WIDTH-1:0] rise_out
);

	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] sync;
	logic [WIDTH-1:0] last;

	initial begin
		if (WIDTH < 1) $error("WIDTH must be positive");
	end

	// Idle high so a trigger line held high at reset gives no edge
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta <= '1;
			sync <= '1;
			last <= '1;
		end else begin
			meta <= pin_in;
			sync <= meta;
			last <= sync;
		end
	end

	assign level_out = sync;
	assign fall_out  = last & ~sync;
	assign rise_out  = ~last & sync;

endmodule : mts_edge_sync

// ===== hdl/mts_sequencer.sv
// Measurement trigger sequencer: arm, trigger and sample stages with trigger storing.
// Assumes a measuring core that ends each reading with a one-cycle done pulse,
// and a register master on the same clock.
`timescale 1ns/100ps
// Behaviour
// - Host request needs empty buffer, memory, request
// - External event is falling edge of trigger
// - Host request once per burst unless sample
// - Host trigger enables edge-by-edge sampling
// - No storing: overlapping trigger ignored, error
// - Storing: latch first overlap, no error
// - Stored trigger used after reading ends
// - Storing off at reset, separate on and off commands
// - Free arm and trigger: reading per sample
// - Edge trigger waits; host sample illegal
// - Level trigger; host or line sample illegal
// - Line trigger; host or level sample illegal
// - One-shot starts burst, then trigger holds if sample free
// - Host trigger and sample share first request
// - Host trigger starts burst for other samples
module mts_sequencer #(
	parameter int COUNT_W = 16
) (
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic [7:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [31:0] rdata_out,
	input  wire logic        ext_trig_b_in,
	input  wire logic        line_cross_in,
	input  wire logic        level_hit_in,
	input  wire logic        timer_tick_in,
	input  wire logic        host_req_in,
	input  wire logic        out_buf_empty_in,
	input  wire logic        mem_off_or_empty_in,
	input  wire logic        reading_done_in,
	output logic             start_reading_out,
	output logic             busy_out,
	output logic             irq_out
);

	initial begin
		if (COUNT_W < 1 || COUNT_W > 16) $error("COUNT_W must be 1..16");
	end

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [3:0] pin_level;
	logic [3:0] pin_fall;
	logic [3:0] pin_rise;

	mts_edge_sync #(
		.WIDTH(4)
	) u_sync (
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.pin_in   ({ext_trig_b_in, line_cross_in, level_hit_in, timer_tick_in}),
		.level_out(pin_level),
		.fall_out (pin_fall),
		.rise_out (pin_rise)
	);

	mts_pkg::mts_events_s ev;
	assign ev.ext_fall   = pin_fall[3];
	assign ev.line_cross = pin_rise[2];
	assign ev.level_hit  = pin_rise[1];
	assign ev.timer_tick = pin_rise[0];
	assign ev.host_req   = host_req_in & out_buf_empty_in & mem_off_or_empty_in;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	mts_pkg::mts_setup_s        setup;
	logic                       store_en;
	logic [COUNT_W-1:0]         count;
	logic [COUNT_W-1:0]         left;
	logic [mts_pkg::MTS_IRQ_W-1:0] irq_stat;
	logic [mts_pkg::MTS_IRQ_W-1:0] irq_mask;
	mts_pkg::mts_state_e        state;
	mts_pkg::mts_state_e        next_state;
	logic                       stored_trig;
	logic                       overlap_seen;
	logic                       sgl_pending;

	wire wr_ctrl  = wr_in && addr_in == mts_pkg::MTS_REG_CTRL;
	wire wr_count = wr_in && addr_in == mts_pkg::MTS_REG_COUNT;
	wire wr_cmd   = wr_in && addr_in == mts_pkg::MTS_REG_CMD;
	wire wr_irq   = wr_in && addr_in == mts_pkg::MTS_REG_IRQ;
	wire wr_mask  = wr_in && addr_in == mts_pkg::MTS_REG_MASK;
	wire cmd_sgl  = wr_cmd && wdata_in[mts_pkg::MTS_CMD_SGL];
	wire cmd_arm  = wr_cmd && wdata_in[mts_pkg::MTS_CMD_ARM];
	wire cmd_pre  = wr_cmd && wdata_in[mts_pkg::MTS_CMD_PRE];
	wire cmd_son  = wr_cmd && wdata_in[mts_pkg::MTS_CMD_SON];
	wire cmd_soff = wr_cmd && wdata_in[mts_pkg::MTS_CMD_SOFF];

	// ----------------------------------------
	// Event selection
	// ----------------------------------------
	function automatic logic ev_hit(input mts_pkg::mts_event_e sel, input mts_pkg::mts_events_s e,
	                                input logic ext_any, input logic one_shot_event);
		case (sel)
			mts_pkg::MTS_EV_AUTO:  ev_hit = 1'b1;
			mts_pkg::MTS_EV_EXT:   ev_hit = ext_any;
			mts_pkg::MTS_EV_SYN:   ev_hit = e.host_req;
			mts_pkg::MTS_EV_SGL:   ev_hit = one_shot_event;
			mts_pkg::MTS_EV_LINE:  ev_hit = e.line_cross;
			mts_pkg::MTS_EV_LEVEL: ev_hit = e.level_hit;
			mts_pkg::MTS_EV_TIMER: ev_hit = e.timer_tick;
			default:               ev_hit = 1'b0;
		endcase
	endfunction : ev_hit

	function automatic logic is_sel(input mts_pkg::mts_event_e sel, input mts_pkg::mts_event_e want);
		is_sel = sel == want;
	endfunction : is_sel

	// Illegal pairs refuse to start a burst; flagged from the written data, not the old setup
	function automatic logic bad_pair(input mts_pkg::mts_event_e t, input mts_pkg::mts_event_e s);
		bad_pair = (is_sel(t, mts_pkg::MTS_EV_EXT) && is_sel(s, mts_pkg::MTS_EV_SYN))
		        || (is_sel(t, mts_pkg::MTS_EV_LEVEL)
		            && (is_sel(s, mts_pkg::MTS_EV_SYN) || is_sel(s, mts_pkg::MTS_EV_LINE)))
		        || (is_sel(t, mts_pkg::MTS_EV_LINE)
		            && (is_sel(s, mts_pkg::MTS_EV_SYN) || is_sel(s, mts_pkg::MTS_EV_LEVEL)));
	endfunction : bad_pair

	wire samp_is_syn = is_sel(setup.samp_sel, mts_pkg::MTS_EV_SYN);
	wire illegal     = bad_pair(setup.trig_sel, setup.samp_sel);
	wire illegal_wr  = bad_pair(mts_pkg::mts_event_e'(wdata_in[mts_pkg::MTS_TRIG_LSB +: mts_pkg::MTS_SEL_W]),
	                            mts_pkg::mts_event_e'(wdata_in[mts_pkg::MTS_SAMP_LSB +: mts_pkg::MTS_SEL_W]));

	wire measuring = state == mts_pkg::MTS_ST_MEAS;
	// A stored trigger stands in for a fresh edge once the reading ends
	wire ext_any   = !measuring && (ev.ext_fall || stored_trig);
	wire arm_hit   = ev_hit(setup.arm_sel, ev, ext_any, sgl_pending);
	wire trig_hit  = ev_hit(setup.trig_sel, ev, ext_any, sgl_pending);
	// One host request serves both stages when trigger and sample are host requests
	wire samp_first = is_sel(setup.trig_sel, mts_pkg::MTS_EV_SYN) && samp_is_syn;
	wire samp_hit  = ev_hit(setup.samp_sel, ev, ext_any, sgl_pending);
	wire ext_used  = ext_any && !stored_trig_keep(state, setup);
	wire last_rdg  = left == COUNT_W'(1);
	wire continuous = is_sel(setup.arm_sel, mts_pkg::MTS_EV_AUTO)
	               && is_sel(setup.trig_sel, mts_pkg::MTS_EV_AUTO)
	               && is_sel(setup.samp_sel, mts_pkg::MTS_EV_AUTO);

	// Stored trigger stays only if the current stage does not use the external edge
	function automatic logic stored_trig_keep(input mts_pkg::mts_state_e st, input mts_pkg::mts_setup_s s);
		case (st)
			mts_pkg::MTS_ST_ARM:  stored_trig_keep = !is_sel(s.arm_sel, mts_pkg::MTS_EV_EXT);
			mts_pkg::MTS_ST_TRIG: stored_trig_keep = !is_sel(s.trig_sel, mts_pkg::MTS_EV_EXT);
			mts_pkg::MTS_ST_SAMP: stored_trig_keep = !is_sel(s.samp_sel, mts_pkg::MTS_EV_EXT);
			default:              stored_trig_keep = 1'b1;
		endcase
	endfunction : stored_trig_keep

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	logic go_meas;
	always_comb begin
		next_state = state;
		go_meas    = 1'b0;
		case (state)
			mts_pkg::MTS_ST_ARM: begin
				if (arm_hit && !illegal && !is_sel(setup.trig_sel, mts_pkg::MTS_EV_HOLD))
					next_state = mts_pkg::MTS_ST_TRIG;
			end
			mts_pkg::MTS_ST_TRIG: begin
				if (is_sel(setup.trig_sel, mts_pkg::MTS_EV_HOLD) || illegal) begin
					next_state = mts_pkg::MTS_ST_ARM;
				end else if (trig_hit) begin
					if (samp_first || is_sel(setup.samp_sel, mts_pkg::MTS_EV_AUTO)) begin
						next_state = mts_pkg::MTS_ST_MEAS;
						go_meas    = 1'b1;
					end else begin
						next_state = mts_pkg::MTS_ST_SAMP;
					end
				end
			end
			mts_pkg::MTS_ST_SAMP: begin
				if (samp_hit) begin
					next_state = mts_pkg::MTS_ST_MEAS;
					go_meas    = 1'b1;
				end
			end
			mts_pkg::MTS_ST_MEAS: begin
				if (reading_done_in)
					next_state = (last_rdg && !continuous) ? mts_pkg::MTS_ST_ARM : mts_pkg::MTS_ST_SAMP;
			end
			default: next_state = mts_pkg::MTS_ST_ARM;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state             <= mts_pkg::MTS_ST_ARM;
			start_reading_out <= 1'b0;
		end else begin
			state             <= cmd_pre ? mts_pkg::MTS_ST_ARM : next_state;
			start_reading_out <= go_meas && !cmd_pre;
		end
	end

	// Counter loads at burst start, counts completed readings
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			left <= '0;
		else if (state == mts_pkg::MTS_ST_TRIG && next_state != mts_pkg::MTS_ST_TRIG)
			left <= count;
		else if (measuring && reading_done_in)
			left <= continuous && last_rdg ? count : left - COUNT_W'(1);
	end

	// ----------------------------------------
	// Trigger storing
	// ----------------------------------------
	wire ext_overlap = measuring && ev.ext_fall;
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			stored_trig  <= 1'b0;
			overlap_seen <= 1'b0;
		end else begin
			if (ext_overlap && store_en)
				stored_trig <= 1'b1;
			else if (!measuring && ext_used)
				stored_trig <= 1'b0;
			overlap_seen <= ext_overlap && !store_en;
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			setup       <= '{mts_pkg::MTS_RST_ARM, mts_pkg::MTS_RST_TRIG, mts_pkg::MTS_RST_SAMP};
			store_en    <= 1'b0;
			count       <= COUNT_W'(mts_pkg::MTS_RST_COUNT);
			sgl_pending <= 1'b0;
		end else begin
			if (cmd_pre) begin
				setup       <= '{mts_pkg::MTS_RST_ARM, mts_pkg::MTS_RST_TRIG, mts_pkg::MTS_RST_SAMP};
				count       <= COUNT_W'(mts_pkg::MTS_RST_COUNT);
			end else if (wr_ctrl) begin
				setup.arm_sel  <= mts_pkg::mts_event_e'(wdata_in[mts_pkg::MTS_ARM_LSB +: mts_pkg::MTS_SEL_W]);
				setup.trig_sel <= mts_pkg::mts_event_e'(wdata_in[mts_pkg::MTS_TRIG_LSB +: mts_pkg::MTS_SEL_W]);
				setup.samp_sel <= mts_pkg::mts_event_e'(wdata_in[mts_pkg::MTS_SAMP_LSB +: mts_pkg::MTS_SEL_W]);
			end else if (go_meas && state == mts_pkg::MTS_ST_TRIG
			             && is_sel(setup.trig_sel, mts_pkg::MTS_EV_SGL)) begin
				setup.trig_sel <= mts_pkg::MTS_EV_HOLD;
			end else if (arm_hit && state == mts_pkg::MTS_ST_ARM
			             && is_sel(setup.arm_sel, mts_pkg::MTS_EV_SGL)) begin
				setup.arm_sel <= mts_pkg::MTS_EV_HOLD;
			end
			if (wr_count)
				count <= wdata_in[COUNT_W-1:0] == '0 ? COUNT_W'(1) : wdata_in[COUNT_W-1:0];
			if (cmd_son)
				store_en <= 1'b1;
			else if (cmd_soff)
				store_en <= 1'b0;
			if (cmd_sgl || cmd_arm)
				sgl_pending <= 1'b1;
			else if (state != mts_pkg::MTS_ST_MEAS && (arm_hit || trig_hit))
				sgl_pending <= 1'b0;
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	logic [mts_pkg::MTS_IRQ_W-1:0] irq_set;
	assign irq_set[mts_pkg::MTS_IRQ_OVL]  = overlap_seen;
	assign irq_set[mts_pkg::MTS_IRQ_ILL]  = wr_ctrl && illegal_wr;
	assign irq_set[mts_pkg::MTS_IRQ_DONE] = measuring && reading_done_in && last_rdg;
	assign irq_set[mts_pkg::MTS_IRQ_RDG]  = measuring && reading_done_in;

	// Set wins over a same-cycle clear
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			irq_stat <= '0;
			irq_mask <= '0;
		end else begin
			irq_stat <= (irq_stat & ~(wr_irq ? wdata_in[mts_pkg::MTS_IRQ_W-1:0] : '0)) | irq_set;
			if (wr_mask)
				irq_mask <= wdata_in[mts_pkg::MTS_IRQ_W-1:0];
		end
	end

	assign irq_out  = |(irq_stat & irq_mask);
	assign busy_out = measuring;

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		case (addr_in)
			mts_pkg::MTS_REG_CTRL: begin
				rd_mux[mts_pkg::MTS_ARM_LSB +: mts_pkg::MTS_SEL_W]  = setup.arm_sel;
				rd_mux[mts_pkg::MTS_TRIG_LSB +: mts_pkg::MTS_SEL_W] = setup.trig_sel;
				rd_mux[mts_pkg::MTS_SAMP_LSB +: mts_pkg::MTS_SEL_W] = setup.samp_sel;
				rd_mux[mts_pkg::MTS_STORE_BIT]                      = store_en;
			end
			mts_pkg::MTS_REG_COUNT:  rd_mux[COUNT_W-1:0] = count;
			mts_pkg::MTS_REG_STATUS: rd_mux[3:0] = {stored_trig, pin_level[3], state};
			mts_pkg::MTS_REG_IRQ:    rd_mux[mts_pkg::MTS_IRQ_W-1:0] = irq_stat;
			mts_pkg::MTS_REG_MASK:   rd_mux[mts_pkg::MTS_IRQ_W-1:0] = irq_mask;
			mts_pkg::MTS_REG_LEFT:   rd_mux[COUNT_W-1:0] = left;
			default:                 rd_mux = '0;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			rdata_out <= '0;
		else
			rdata_out <= rd_en_mux(rd_in, rd_mux);
	end

	function automatic logic [31:0] rd_en_mux(input logic en, input logic [31:0] d);
		rd_en_mux = en ? d : 32'h0000_0000;
	endfunction : rd_en_mux

endmodule : mts_sequencer

// ===== verif/mts_checker.sv
// Checker for the trigger sequencer: timing relations at the top ports.
// Assumes a single clock; bound to the sequencer below.
`timescale 1ns/100ps
module mts_checker #(
	parameter int COUNT_W = 16
) (
	input wire logic        clk_in,
	input wire logic        rst_b_in,
	input wire logic [7:0]  addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic        wr_in,
	input wire logic        rd_in,
	input wire logic [31:0] rdata_out,
	input wire logic        ext_trig_b_in,
	input wire logic        line_cross_in,
	input wire logic        level_hit_in,
	input wire logic        timer_tick_in,
	input wire logic        host_req_in,
	input wire logic        out_buf_empty_in,
	input wire logic        mem_off_or_empty_in,
	input wire logic        reading_done_in,
	input wire logic        start_reading_out,
	input wire logic        busy_out,
	input wire logic        irq_out
);
	// ----------------------------------------
	// Setup write decode
	// ----------------------------------------
	wire logic       wr_ctrl = wr_in && (addr_in == mts_pkg::MTS_REG_CTRL);
	wire logic [2:0] trig_w  = wdata_in[6:4];
	wire logic [2:0] samp_w  = wdata_in[10:8];
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	AST_START_ONE: assert property (start_reading_out |=> !start_reading_out)
		else $error("start pulse longer than one cycle");
	AST_START_BUSY: assert property (start_reading_out |-> busy_out)
		else $error("start without busy");
	AST_BUSY_HOLD: assert property (busy_out && !reading_done_in |=> busy_out)
		else $error("busy dropped before done");
	AST_DONE_FREE: assert property (busy_out && reading_done_in |=> !busy_out)
		else $error("busy kept after done");
	AST_NO_RESTART: assert property (busy_out |=> !start_reading_out)
		else $error("start during a reading");
	// Write sampled in any state; two cycles allowed for a start already launched, then six checked
	AST_EXT_SYN_BAD: assert property (wr_ctrl && trig_w == 3'h1 && samp_w == 3'h2
		|-> ##2 !start_reading_out [*6]) else $error("illegal edge setup started");
	AST_LEVEL_BAD: assert property (wr_ctrl && trig_w == 3'h5 && (samp_w == 3'h2 || samp_w == 3'h4)
		|-> ##2 !start_reading_out [*6]) else $error("illegal level setup started");
	AST_LINE_BAD: assert property (wr_ctrl && trig_w == 3'h4 && (samp_w == 3'h2 || samp_w == 3'h5)
		|-> ##2 !start_reading_out [*6]) else $error("illegal line setup started");
endmodule : mts_checker
bind mts_sequencer mts_checker #(.COUNT_W(COUNT_W)) u_chk (
	.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
	.rd_in(rd_in), .rdata_out(rdata_out), .ext_trig_b_in(ext_trig_b_in), .line_cross_in(line_cross_in),
	.level_hit_in(level_hit_in), .timer_tick_in(timer_tick_in), .host_req_in(host_req_in),
	.out_buf_empty_in(out_buf_empty_in), .mem_off_or_empty_in(mem_off_or_empty_in),
	.reading_done_in(reading_done_in), .start_reading_out(start_reading_out), .busy_out(busy_out),
	.irq_out(irq_out));

// ===== verif/mts_core_model.sv
// Measuring core model: answers each start with a one-cycle done pulse.
// Assumes the sequencer clock; slow_in picks a long reading for overlap tests.
`timescale 1ns/100ps
module mts_core_model (
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	input  wire logic start_in,
	input  wire logic slow_in,
	output logic      done_out
);
	// ----------------------------------------
	// Reading length counter
	// ----------------------------------------
	logic [5:0] left;
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			left <= 6'h00;
			done_out <= 1'b0;
		end else begin
			done_out <= (left == 6'h01);
			// Long reading leaves room for triggers to overlap it
			if (start_in)
				left <= slow_in ? 6'h14 : 6'h02;
			else if (left != 6'h00)
				left <= left - 6'h01;
		end
	end
endmodule : mts_core_model

// ===== verif/testbench.sv
// Testbench for the trigger sequencer: register tasks, event stimulus, read monitor.
// Assumes the core model file and the bound checker.
`timescale 1ns/100ps
module testbench;
	logic        clk_in = 1'b0, rst_b_in = 1'b0, wr = 1'b0, rd = 1'b0, ext_b = 1'b1, host = 1'b0;
	logic        buf_empty = 1'b1, mem_empty = 1'b1, slow = 1'b0, rd_p1 = 1'b0, start, busy, irq, done;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [31:0] bad [5] = '{32'h210, 32'h250, 32'h450, 32'h240, 32'h540};
	logic [31:0] exp_q [$];
	string       name_q [$];
	int          err_count = 0, checks = 0, start_cnt = 0, base, n, seed = 32'h7ca2;
	initial begin
		forever #5 clk_in = ~clk_in;
	end
	mts_sequencer dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
		.rd_in(rd), .rdata_out(rdata), .ext_trig_b_in(ext_b), .line_cross_in(1'b0), .level_hit_in(1'b0),
		.timer_tick_in(1'b0), .host_req_in(host), .out_buf_empty_in(buf_empty),
		.mem_off_or_empty_in(mem_empty), .reading_done_in(done), .start_reading_out(start),
		.busy_out(busy), .irq_out(irq));
	mts_core_model core (.clk_in(clk_in), .rst_b_in(rst_b_in), .start_in(start), .slow_in(slow),
		.done_out(done));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_in);
	endtask : cyc
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input string nm, input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		name_q.push_back(nm);
		@(posedge clk_in);
		rd <= 1'b0;
	endtask : rd_reg
	task automatic ext_pulse();
		@(posedge clk_in);
		ext_b <= 1'b0;
		cyc(4);
		ext_b <= 1'b1;
		cyc(4);
	endtask : ext_pulse
	task automatic host_pulse();
		@(posedge clk_in);
		host <= 1'b1;
		@(posedge clk_in);
		host <= 1'b0;
	endtask : host_pulse
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	// ----------------------------------------
	// Read monitor and watchdog
	// ----------------------------------------
	always @(posedge clk_in) begin
		rd_p1 <= rd;
		if (start === 1'b1)
			start_cnt <= start_cnt + 1;
		if (rd_p1 && exp_q.size() > 0)
			chk(name_q.pop_front(), exp_q.pop_front(), rdata);
	end
	initial begin
		cyc(20000);
		err_count++;
		tally_and_finish();
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		cyc(8);
		rst_b_in <= 1'b1;
		rd_reg("ctrl", mts_pkg::MTS_REG_CTRL, 32'h20);
		rd_reg("count", mts_pkg::MTS_REG_COUNT, 32'h1);
		rd_reg("mask", mts_pkg::MTS_REG_MASK, 32'h0);
		rd_reg("unmapped", 8'h1c, 32'h0);
		$display("test reset done");
		n = 2 + $unsigned($random(seed)) % 3;
		wr_reg(mts_pkg::MTS_REG_COUNT, n);
		wr_reg(mts_pkg::MTS_REG_CTRL, 32'h120);
		buf_empty <= 1'b0;
		host <= 1'b1;
		cyc(10);
		rd_reg("status", mts_pkg::MTS_REG_STATUS, 32'h5);
		buf_empty <= 1'b1;
		cyc(12);
		host <= 1'b0;
		rd_reg("status", mts_pkg::MTS_REG_STATUS, 32'h6);
		for (int i = 0; i < n; i++) begin
			ext_pulse();
			cyc(4);
			if (i == 0)
				rd_reg("left", mts_pkg::MTS_REG_LEFT, n - 1);
		end
		cyc(4);
		rd_reg("irq", mts_pkg::MTS_REG_IRQ, 32'hc);
		wr_reg(mts_pkg::MTS_REG_IRQ, 32'hf);
		rd_reg("status", mts_pkg::MTS_REG_STATUS, 32'h5);
		$display("test edge samples done");
		wr_reg(mts_pkg::MTS_REG_MASK, 32'h1);
		wr_reg(mts_pkg::MTS_REG_COUNT, 32'h1);
		slow <= 1'b1;
		host_pulse();
		cyc(4);
		ext_pulse();
		ext_pulse();
		cyc(20);
		chk("irq_out", 32'h1, {31'h0, irq});
		rd_reg("irq", mts_pkg::MTS_REG_IRQ, 32'hd);
		rd_reg("status", mts_pkg::MTS_REG_STATUS, 32'h5);
		wr_reg(mts_pkg::MTS_REG_IRQ, 32'hf);
		cyc(2);
		chk("irq_out", 32'h0, {31'h0, irq});
		$display("test overlap done");
		wr_reg(mts_pkg::MTS_REG_CMD, 32'h8);
		rd_reg("ctrl", mts_pkg::MTS_REG_CTRL, 32'h1120);
		wr_reg(mts_pkg::MTS_REG_COUNT, 32'h2);
		host_pulse();
		cyc(4);
		ext_pulse();
		ext_pulse();
		rd_reg("status", mts_pkg::MTS_REG_STATUS, 32'hf);
		cyc(50);
		rd_reg("irq", mts_pkg::MTS_REG_IRQ, 32'hc);
		rd_reg("status", mts_pkg::MTS_REG_STATUS, 32'h5);
		wr_reg(mts_pkg::MTS_REG_CMD, 32'h10);
		rd_reg("ctrl", mts_pkg::MTS_REG_CTRL, 32'h120);
		wr_reg(mts_pkg::MTS_REG_IRQ, 32'hf);
		slow <= 1'b0;
		$display("test storing done");
		foreach (bad[i]) begin
			wr_reg(mts_pkg::MTS_REG_CTRL, bad[i]);
			cyc(4);
			rd_reg("irq", mts_pkg::MTS_REG_IRQ, 32'h2);
			wr_reg(mts_pkg::MTS_REG_IRQ, 32'hf);
		end
		$display("test illegal done");
		wr_reg(mts_pkg::MTS_REG_CTRL, 32'h30);
		wr_reg(mts_pkg::MTS_REG_COUNT, 32'h2);
		wr_reg(mts_pkg::MTS_REG_CMD, 32'h1);
		cyc(20);
		rd_reg("ctrl", mts_pkg::MTS_REG_CTRL, 32'h70);
		rd_reg("irq", mts_pkg::MTS_REG_IRQ, 32'hc);
		wr_reg(mts_pkg::MTS_REG_IRQ, 32'hf);
		$display("test one shot done");
		base = start_cnt;
		wr_reg(mts_pkg::MTS_REG_CTRL, 32'h0);
		cyc(100);
		chk("readings", 32'h1, {31'h0, (start_cnt - base) > 10});
		wr_reg(mts_pkg::MTS_REG_CTRL, 32'h20);
		cyc(30);
		wr_reg(mts_pkg::MTS_REG_IRQ, 32'hf);
		$display("test free run done");
		wr_reg(mts_pkg::MTS_REG_CTRL, 32'h220);
		host_pulse();
		cyc(8);
		rd_reg("left", mts_pkg::MTS_REG_LEFT, 32'h1);
		host_pulse();
		cyc(8);
		rd_reg("irq", mts_pkg::MTS_REG_IRQ, 32'hc);
		cyc(4);
		$display("test host sample done");
		tally_and_finish();
	end
endmodule : testbench
